// file: dbol_arbiter.sv
`timescale 1ns/100ps
`default_nettype none

module dbol_arbiter
    import dbol_pkg::*;
#(
    parameter int REFRESH_COUNT_W = 4,
    parameter int UNIT_CYCLES = DBOL_UNIT_CYCLES
)
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // register bus
    input wire logic i_hsel,
    input wire logic [13:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // display controller
    input wire logic i_line_sent,
    input wire logic i_display_busy,
    output logic o_display_fetch_dma_ack,
    // refresh
    input wire logic i_refresh_due,
    input wire logic i_refresh_done,
    output logic o_refresh_bus_cycle_ack,
    output logic [REFRESH_COUNT_W-1:0] o_refresh_pending,
    // general DMA
    input wire logic i_general_dma_transfer_req,
    output logic o_general_dma_transfer_ack,
    output logic o_general_dma_forced_end,
    // CPU
    input wire logic i_cpu_req,
    output logic o_cpu_ack
);

    localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

    dbol_regs_if regs ();

    dbol_owner_t owner_r;
    dbol_owner_t owner_nxt;
    logic display_req_r;
    logic display_req_nxt;
    logic [REFRESH_COUNT_W-1:0] refresh_cnt_r;
    logic [REFRESH_COUNT_W-1:0] refresh_cnt_nxt;
    logic [1:0] gen_wait_r;
    logic [1:0] gen_wait_nxt;
    logic [15:0] sub_r;
    logic [15:0] sub_nxt;
    logic [6:0] units_r;
    logic [6:0] units_nxt;
    logic forced_r;
    logic forced_nxt;
    logic limit_hit;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    dbol_ahb_regs u_regs (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hwdata(i_hwdata),
        .i_hready(i_hready),
        .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .regs(regs.slave)
    );

    // ------------------------------------------------------------
    // occupancy limit compare
    // ------------------------------------------------------------
    // a zero limit is not legal; treated as never reached
    // hit on the last clock of the last unit, so a tenure lasts exactly units * UNIT_CYCLES clocks
    assign limit_hit = regs.limit_timer_enable && (regs.limit_time_units != 7'h00)
        && (sub_r == UNIT_LAST) && ((units_r + 7'h01) == regs.limit_time_units);

    // arbitration, refresh backlog, occupancy timer
    always_comb
    begin
        owner_nxt = owner_r;
        display_req_nxt = display_req_r;
        refresh_cnt_nxt = refresh_cnt_r;
        gen_wait_nxt = 2'b00;
        sub_nxt = 16'h0000;
        units_nxt = 7'h00;
        forced_nxt = forced_r && i_general_dma_transfer_req;
        if (i_line_sent)
            display_req_nxt = 1'b1;
        if (i_refresh_due && !(refresh_cnt_r == {REFRESH_COUNT_W{1'b1}}))
            refresh_cnt_nxt = refresh_cnt_r + 1'b1;
        if (owner_r == DBOL_OWN_REFRESH && i_refresh_done && !i_refresh_due)
            refresh_cnt_nxt = refresh_cnt_r - 1'b1;
        case (owner_r)
            DBOL_OWN_NONE:
            begin
                if (display_req_r)
                    owner_nxt = DBOL_OWN_DISPLAY;
                else if (refresh_cnt_r != '0)
                    owner_nxt = DBOL_OWN_REFRESH;
                else if (i_general_dma_transfer_req && !forced_r)
                begin
                    gen_wait_nxt = gen_wait_r + 2'b01;
                    if (gen_wait_r == 2'(DBOL_OVERHEAD_STATES - 1))
                        owner_nxt = DBOL_OWN_GENERAL;
                end
                else if (i_cpu_req)
                    owner_nxt = DBOL_OWN_CPU;
            end
            DBOL_OWN_DISPLAY:
            begin
                display_req_nxt = i_line_sent;
                if (!i_display_busy && !display_req_r)
                    owner_nxt = DBOL_OWN_NONE;
            end
            DBOL_OWN_REFRESH:
            begin
                if (i_refresh_done && refresh_cnt_r == REFRESH_COUNT_W'(1) && !i_refresh_due)
                    owner_nxt = DBOL_OWN_NONE;
            end
            DBOL_OWN_GENERAL:
            begin
                sub_nxt = (sub_r == UNIT_LAST) ? 16'h0000 : sub_r + 16'h0001;
                units_nxt = (sub_r == UNIT_LAST) ? units_r + 7'h01 : units_r;
                // display waits for release; only end of transfer or limit frees bus
                if (!i_general_dma_transfer_req)
                    owner_nxt = DBOL_OWN_NONE;
                else if (limit_hit)
                begin
                    owner_nxt = DBOL_OWN_NONE;
                    forced_nxt = 1'b1;
                end
            end
            DBOL_OWN_CPU:
            begin
                if (!i_cpu_req || display_req_r || refresh_cnt_r != '0
                    || i_general_dma_transfer_req)
                    owner_nxt = DBOL_OWN_NONE;
            end
            default:
                owner_nxt = DBOL_OWN_NONE;
        endcase
        if (owner_nxt != DBOL_OWN_GENERAL)
        begin
            sub_nxt = 16'h0000;
            units_nxt = 7'h00;
        end
        // a forced end lets the bus go one round before re-request
        if (owner_r != DBOL_OWN_GENERAL && owner_r != DBOL_OWN_NONE)
            forced_nxt = 1'b0;
        if (owner_r == DBOL_OWN_NONE && (display_req_r || refresh_cnt_r != '0 || i_cpu_req))
            forced_nxt = 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            owner_r <= DBOL_OWN_NONE;
            display_req_r <= 1'b0;
            refresh_cnt_r <= '0;
            gen_wait_r <= 2'b00;
            sub_r <= 16'h0000;
            units_r <= 7'h00;
            forced_r <= 1'b0;
        end
        else
        begin
            owner_r <= owner_nxt;
            display_req_r <= display_req_nxt;
            refresh_cnt_r <= refresh_cnt_nxt;
            gen_wait_r <= gen_wait_nxt;
            sub_r <= sub_nxt;
            units_r <= units_nxt;
            forced_r <= forced_nxt;
        end
    end

    // ------------------------------------------------------------
    // acknowledges
    // ------------------------------------------------------------
    assign o_display_fetch_dma_ack = (owner_r == DBOL_OWN_DISPLAY);
    assign o_refresh_bus_cycle_ack = (owner_r == DBOL_OWN_REFRESH);
    assign o_general_dma_transfer_ack = (owner_r == DBOL_OWN_GENERAL);
    assign o_cpu_ack = (owner_r == DBOL_OWN_CPU);
    assign o_general_dma_forced_end = forced_r;
    assign o_refresh_pending = refresh_cnt_r;

endmodule : dbol_arbiter

`default_nettype wire

// file: dbol_pkg.sv
`default_nettype none

package dbol_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] DBOL_LIMIT_OFFSET = 12'h97f;      // register index
    localparam logic [13:0] DBOL_LIMIT_ADDR = {DBOL_LIMIT_OFFSET, 2'b00};
    localparam logic [7:0] DBOL_LIMIT_RESET = 8'h00;
    localparam int DBOL_ENABLE_BIT = 7;
    localparam int DBOL_UNITS_MSB = 6;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int DBOL_UNIT_CYCLES = 256;                     // clocks per limit unit
    localparam int DBOL_OVERHEAD_STATES = 2;                   // request to acknowledge
    localparam int DBOL_CLOCK_MHZ = 25;

    // bus owner encoding
    typedef enum logic [2:0] {
        DBOL_OWN_NONE,
        DBOL_OWN_DISPLAY,
        DBOL_OWN_REFRESH,
        DBOL_OWN_GENERAL,
        DBOL_OWN_CPU
    } dbol_owner_t;

endpackage : dbol_pkg

`default_nettype wire

// file: dbol_regs_if.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// register contents passed from bus slave to arbiter
// ------------------------------------------------------------
interface dbol_regs_if;
    logic limit_timer_enable;
    logic [6:0] limit_time_units;
    modport slave (output limit_timer_enable, output limit_time_units);
    modport core (input limit_timer_enable, input limit_time_units);
endinterface : dbol_regs_if

`default_nettype wire

// file: dbol_ahb_regs.sv
`timescale 1ns/100ps
`default_nettype none

module dbol_ahb_regs
    import dbol_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [13:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    dbol_regs_if.slave regs
);

    logic [7:0] limit_r;
    logic [7:0] limit_nxt;
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic hit;

    // ------------------------------------------------------------
    // address decode and register update
    // ------------------------------------------------------------
    assign hit = (i_haddr == DBOL_LIMIT_ADDR);

    // capture address phase, write in data phase, read data registered
    always_comb
    begin
        limit_nxt = limit_r;
        wr_pend_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (wr_pend_r)
            limit_nxt = i_hwdata[7:0];
        if (i_hsel && i_hready && i_htrans[1])
        begin
            wr_pend_nxt = i_hwrite && hit;
            rdata_nxt = (hit && !i_hwrite) ? {24'h000000, limit_r} : 32'h00000000;
            if (wr_pend_r && hit && !i_hwrite)
                rdata_nxt = {24'h000000, i_hwdata[7:0]};
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            limit_r <= DBOL_LIMIT_RESET;
            wr_pend_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            limit_r <= limit_nxt;
            wr_pend_r <= wr_pend_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_hrdata = rdata_r;
    assign o_hreadyout = 1'b1;                                 // zero wait states
    assign o_hresp = 1'b0;                                     // always OKAY
    assign regs.limit_timer_enable = limit_r[DBOL_ENABLE_BIT];
    assign regs.limit_time_units = limit_r[DBOL_UNITS_MSB:0];

endmodule : dbol_ahb_regs

`default_nettype wire

// file: dbol_arbiter_assertions.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// port checker for the arbiter
// ------------------------------------------------------------
module dbol_arbiter_assertions
#(
    parameter int REFRESH_COUNT_W = 4
)
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_line_sent,
    input wire logic i_general_dma_transfer_req,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_display_fetch_dma_ack,
    input wire logic o_refresh_bus_cycle_ack,
    input wire logic [REFRESH_COUNT_W-1:0] o_refresh_pending,
    input wire logic o_general_dma_transfer_ack,
    input wire logic o_general_dma_forced_end,
    input wire logic o_cpu_ack
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    // general dma owns the bus while the display asks for it
    sequence s_display_due;
        o_general_dma_transfer_ack && i_line_sent;
    endsequence

    // bus grants and handshake relations
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready or not okay");
    a_single_owner: assert property ($onehot0({o_display_fetch_dma_ack, o_refresh_bus_cycle_ack,
        o_general_dma_transfer_ack, o_cpu_ack})) else $error("two bus owners");
    a_dma_overhead: assert property ($rose(o_general_dma_transfer_ack) |->
        $past(i_general_dma_transfer_req, 1) && $past(i_general_dma_transfer_req, 2))
        else $error("dma grant before two cycles of request");
    a_display_waits: assert property (s_display_due |=> !o_display_fetch_dma_ack)
        else $error("display took bus from dma");
    a_forced_release: assert property ($rose(o_general_dma_forced_end) |->
        $fell(o_general_dma_transfer_ack)) else $error("forced end without release");
    a_fend_no_grant: assert property (o_general_dma_forced_end |-> !o_general_dma_transfer_ack)
        else $error("dma granted while forced end");
    a_cpu_lowest: assert property ($rose(o_cpu_ack) |->
        !$past(i_general_dma_transfer_req && !o_general_dma_forced_end))
        else $error("cpu won over dma");
    a_refresh_backlog: assert property ($fell(o_display_fetch_dma_ack) && !i_line_sent &&
        !$past(i_line_sent) && o_refresh_pending != 0 |-> ##[1:3] o_refresh_bus_cycle_ack)
        else $error("backlog not run");
    a_display_served: assert property (i_line_sent && !o_general_dma_transfer_ack && !o_cpu_ack &&
        !o_refresh_bus_cycle_ack && o_refresh_pending == 0 && !i_general_dma_transfer_req
        |-> ##[1:3] o_display_fetch_dma_ack) else $error("fetch not served");
endmodule : dbol_arbiter_assertions

bind dbol_arbiter dbol_arbiter_assertions #(.REFRESH_COUNT_W(REFRESH_COUNT_W)) dbol_arbiter_assertions_i (
    .i_clock, .i_sys_rst, .i_line_sent, .i_general_dma_transfer_req, .o_hreadyout, .o_hresp,
    .o_display_fetch_dma_ack, .o_refresh_bus_cycle_ack, .o_refresh_pending,
    .o_general_dma_transfer_ack, .o_general_dma_forced_end, .o_cpu_ack);

`default_nettype wire

// file: dbol_partner.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// display controller and refresh source model
// ------------------------------------------------------------
module dbol_partner
#(
    parameter int HOLD = 16
)
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_line_go,
    input wire logic i_due_go,
    input wire logic i_display_ack,
    input wire logic i_refresh_ack,
    output logic o_line_sent,
    output logic o_display_busy,
    output logic o_refresh_due,
    output logic o_refresh_done
);
    int cnt_r;

    // line handed over, fetch held for HOLD granted cycles, one refresh per two cycles
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_line_sent <= 1'b0;
            o_display_busy <= 1'b0;
            o_refresh_due <= 1'b0;
            o_refresh_done <= 1'b0;
            cnt_r <= 0;
        end
        else
        begin
            o_line_sent <= i_line_go;
            cnt_r <= i_display_ack ? cnt_r + 1 : 0;
            if (o_line_sent)
                o_display_busy <= 1'b1;
            else if (cnt_r >= HOLD)
                o_display_busy <= 1'b0;
            o_refresh_due <= i_due_go;
            o_refresh_done <= i_refresh_ack && !o_refresh_done;
        end
    end
endmodule : dbol_partner

`default_nettype wire

// file: dbol_arbiter_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dbol_arbiter_tb;
    import dbol_pkg::*;
    localparam int UNITS = 4;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, lgo = 0, dgo = 0, greq = 0, creq = 0;
    logic [13:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic [31:0] hwdata = '0, hrdata, rd;
    logic hready, hresp, line, busy, due, done, dack, rack, gack, fend, cack;
    logic [3:0] pend;
    int n_fail = 0, tests_run = 0;

    always #20 clk = ~clk;

    dbol_arbiter #(.UNIT_CYCLES(UNITS)) dbol_arbiter_i (.i_clock(clk), .i_sys_rst(rst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_line_sent(line), .i_display_busy(busy), .o_display_fetch_dma_ack(dack),
        .i_refresh_due(due), .i_refresh_done(done), .o_refresh_bus_cycle_ack(rack),
        .o_refresh_pending(pend), .i_general_dma_transfer_req(greq), .o_general_dma_transfer_ack(gack),
        .o_general_dma_forced_end(fend), .i_cpu_req(creq), .o_cpu_ack(cack));
    dbol_partner dbol_partner_i (.i_clock(clk), .i_sys_rst(rst), .i_line_go(lgo), .i_due_go(dgo),
        .i_display_ack(dack), .i_refresh_ack(rack), .o_line_sent(line), .o_display_busy(busy),
        .o_refresh_due(due), .o_refresh_done(done));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wt(ref logic s);
        for (int i = 0; i < 60 && s !== 1'b1; i++) @(posedge clk);
    endtask : wt

    task ahb(input logic w, input logic [13:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task pulse_line;
        lgo <= 1'b1;
        @(posedge clk);
        lgo <= 1'b0;
    endtask : pulse_line

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        ahb(0, DBOL_LIMIT_ADDR, 0);
        chk("reset value", rd, {24'h0, DBOL_LIMIT_RESET});
        ahb(1, DBOL_LIMIT_ADDR, 32'hffff_ff87);
        ahb(0, DBOL_LIMIT_ADDR, 0);
        chk("readback", rd, 32'h0000_0087);
        ahb(1, 14'h0010, 32'h0000_0012);
        ahb(0, 14'h0010, 0);
        chk("unmapped", rd, 32'h0);
        ahb(0, DBOL_LIMIT_ADDR, 0);
        chk("untouched", rd, 32'h0000_0087);
    endtask : t_regs

    task t_limit;
        int w;
        int n;
        ahb(1, DBOL_LIMIT_ADDR, 32'h82);
        repeat (2)
        begin
            w = 0;
            n = 0;
            greq <= 1'b1;
            do begin @(posedge clk); w++; end while (gack !== 1'b1 && w < 50);
            chk("overhead", w - 1, DBOL_OVERHEAD_STATES);
            do begin @(posedge clk); n++; end while (gack === 1'b1 && n < 500);
            chk("tenure", n, 2 * UNITS);
            chk("forced end", fend, 1);
            cyc(3);
            chk("refused", gack, 0);
            greq <= 1'b0;
            cyc(2);
            chk("end cleared", fend, 0);
        end
    endtask : t_limit

    task t_hold;
        int n;
        ahb(1, DBOL_LIMIT_ADDR, 32'h01);
        greq <= 1'b1;
        cyc(4);
        pulse_line();
        n = 0;
        repeat (30) begin @(posedge clk); n += (gack === 1'b1 && dack === 1'b0); end
        chk("dma held", n, 30);
        chk("no end", fend, 0);
        greq <= 1'b0;
        wt(dack);
        chk("display after", dack, 1);
        cyc(30);
    endtask : t_hold

    task t_refresh;
        int r;
        pulse_line();
        wt(dack);
        repeat (3) begin dgo <= 1'b1; @(posedge clk); dgo <= 1'b0; @(posedge clk); end
        cyc(2);
        chk("backlog", pend, 3);
        chk("display kept", dack, 1);
        wt(rack);
        r = 0;
        while (rack === 1'b1 && r < 40) begin r += done; @(posedge clk); end
        chk("back to back", r, 3);
        chk("drained", pend, 0);
    endtask : t_refresh

    task t_cpu;
        creq <= 1'b1;
        wt(cack);
        chk("cpu grant", cack, 1);
        greq <= 1'b1;
        wt(gack);
        chk("dma grant", gack, 1);
        chk("cpu out", cack, 0);
        greq <= 1'b0;
        creq <= 1'b0;
        cyc(4);
    endtask : t_cpu

    task end_of_test;
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // main sequence
    initial
    begin
        cyc(16);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_limit();
        t_hold();
        t_refresh();
        t_cpu();
        end_of_test();
    end

    // watchdog
    initial
    begin
        cyc(3000);
        n_fail++;
        end_of_test();
    end
endmodule : dbol_arbiter_tb

`default_nettype wire
